// [tunnel_pkg.sv]
// Constants and types shared by the tunnel read/write relay
package tunnel_pkg;

    // ----------------------------------------
    // RF command and response codes
    // ----------------------------------------
    localparam logic [7:0] rf_read_code       = 8'h06;  // Tunnel read, JIS side
    localparam logic [7:0] rf_read_resp_code  = 8'h07;  // Read response code
    localparam logic [7:0] rf_write_code      = 8'h08;  // Tunnel write, JIS side
    localparam logic [7:0] rf_write_resp_code = 8'h09;  // Write response code
    localparam logic [7:0] iso_read_ins       = 8'hb0;  // Read instruction
    localparam logic [7:0] iso_write_ins      = 8'hd6;  // Write instruction
    localparam logic [7:0] iso_class_ok       = 8'h00;  // Only class accepted

    // ----------------------------------------
    // Host command codes
    // ----------------------------------------
    localparam logic [7:0] host_query         = 8'h28;  // QUERY
    localparam logic [7:0] host_answer_ok     = 8'hf8;  // ANSWER, normal end
    localparam logic [7:0] host_answer_err    = 8'he8;  // ANSWER, error

    // ----------------------------------------
    // Host status bytes and RF status values
    // ----------------------------------------
    localparam logic [7:0] stat_normal        = 8'h00;  // Serial status: normal end
    localparam logic [7:0] stat_unimpl        = 8'h01;  // Serial status: unimplemented
    localparam logic [7:0] stat_rd_detect     = 8'h02;  // Serial status: read pending
    localparam logic [7:0] stat_wr_detect     = 8'h03;  // Serial status: write pending
    localparam logic [7:0] flag_ok            = 8'h00;  // Status flag, normal end
    localparam logic [7:0] flag_err           = 8'hff;  // Status flag, error
    localparam logic [7:0] flag_err2          = 8'ha1;  // Status flag 2, error
    localparam logic [7:0] sw1_ok             = 8'h90;  // Status word, normal end
    localparam logic [7:0] sw1_err            = 8'h6a;  // Status word, error
    localparam logic [7:0] sw2_ok             = 8'h00;  // Status word 2, normal
    localparam logic [7:0] sw2_err            = 8'h80;  // Status word 2, error

    // ----------------------------------------
    // Limits and sizes
    // ----------------------------------------
    localparam int          id_bytes          = 8;      // Card identifier length
    localparam int          block_bytes       = 16;     // Bytes per block
    localparam logic [7:0] svc_min            = 8'h01;  // Service count floor
    localparam logic [7:0] svc_max            = 8'h0b;  // Service count ceiling
    localparam logic [7:0] svc_split          = 8'h08;  // Up to here, 12 blocks
    localparam logic [7:0] blk_max_lo         = 8'h0c;  // Blocks, 1 to 8 services
    localparam logic [7:0] blk_max_hi         = 8'h0b;  // Blocks, 9 to 11 services
    localparam logic [7:0] iso_rd_max         = 8'hfb;  // Read length ceiling
    localparam int          buf_depth         = 256;    // Payload buffer bytes

    // Which framing a transaction uses
    typedef enum logic {frame_jis, frame_iso} frame_type;

endpackage

// [tunnel_check.sv]
// Validity check of a parsed RF tunnel command header
`timescale 1ns/1ns
module tunnel_check (
    input  wire logic       is_iso,     // ISO framing
    input  wire logic       is_write,   // Write, not read
    input  wire logic [7:0] class_byte, // ISO class byte
    input  wire logic [7:0] svc_count,  // JIS service count
    input  wire logic       svc_same,   // All listed identifiers equal
    input  wire logic [7:0] blk_count,  // JIS block count
    input  wire logic [7:0] length,     // ISO read length
    output logic            ok          // Header acceptable
);
    logic [7:0] blk_limit;  // Block ceiling for this service count

    // ----------------------------------------
    // Range checks
    // ----------------------------------------
    always_comb begin
        blk_limit = (svc_count <= tunnel_pkg::svc_split) ? tunnel_pkg::blk_max_lo : tunnel_pkg::blk_max_hi;
        if (is_iso) begin
            ok = (class_byte == tunnel_pkg::iso_class_ok) && (is_write || (length != 8'h00 &&
                 length <= tunnel_pkg::iso_rd_max));
        end else if (is_write) begin
            // identifiers all equal
            // A single listed identifier is trivially equal to itself
            ok = svc_count >= tunnel_pkg::svc_min && svc_count <= tunnel_pkg::svc_max &&
                 (svc_same || svc_count == tunnel_pkg::svc_min) &&
                 blk_count != 8'h00 && blk_count <= blk_limit;
        end else begin
            // Read side: nonzero counts, identifiers equal
            ok = svc_count != 8'h00 && (svc_same || svc_count == tunnel_pkg::svc_min) && blk_count != 8'h00;
        end
    end
endmodule // tunnel_check

// [tunnel_relay.sv]
// Tunnel read/write relay between RF reader and serial host
// What this block does
// - JIS read response: 07, id, flags, count, data
// - JIS error response omits count and data
// - Read data comes from host ANSWER
// - ISO read: data then SW, data only ok
// - Service count 1 to 11 on writes, nonzero on reads, else error
// - Listed service identifiers must be equal
// - Write block limit 12 or 11 by services
// - ISO write INS D6, class nonzero errors
// - Write QUERY: code, address MSB first, length
// - Write QUERY then n data bytes
`timescale 1ns/1ns
module tunnel_relay (
    input  wire logic       clock,       // 100 MHz system clock
    input  wire logic       resetn,      // Asynchronous reset, active low
    // RF side: parsed command header, then payload bytes
    input  wire logic       rf_start,    // Pulse: header fields valid
    input  wire logic       rf_iso,      // ISO framing
    input  wire logic       rf_write,    // Write command
    input  wire logic [7:0] rf_class,    // ISO class byte
    input  wire logic [7:0] rf_svc,      // JIS service count
    input  wire logic       rf_svc_same, // JIS identifiers equal
    input  wire logic [7:0] rf_blocks,   // JIS block count
    input  wire logic [15:0] rf_addr,    // Start address in bytes
    input  wire logic [7:0] rf_len,      // Byte length of transfer
    input  wire logic [63:0] rf_id,      // Card identifier
    input  wire logic       rf_in_valid, // Write payload byte valid
    input  wire logic [7:0] rf_in_data,  // Write payload byte
    output logic            rf_out_valid,// RF response byte valid
    output logic [7:0]      rf_out_data, // RF response byte
    output logic            rf_out_last, // Last response byte
    input  wire logic       rf_out_ready,// RF side takes byte
    // Host side: command bytes in, response bytes out
    input  wire logic       host_in_valid, // Host byte valid
    input  wire logic [7:0] host_in_data,  // Host byte
    input  wire logic       host_in_last,  // Last byte of host command
    output logic            host_out_valid,// Response byte valid
    output logic [7:0]      host_out_data, // Response byte
    output logic            host_out_last, // Last response byte
    input  wire logic       host_out_ready,// Host takes byte
    output logic            busy           // Tunnel transaction open
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef enum logic [2:0] {idle, gather, wait_query, send_query, wait_answer, take_data,
                              send_ack, send_rf} state_type;

    state_type   state, next_state;    // Sequencer
    logic [7:0]  mem [tunnel_pkg::buf_depth];  // Payload bytes
    logic        iso, next_iso;        // Framing latched
    logic        wr, next_wr;          // Direction latched
    logic        good, next_good;      // Outcome is normal end
    logic [7:0]  blocks, next_blocks;  // JIS block count
    logic [15:0] addr, next_addr;      // Start address
    logic [7:0]  len, next_len;        // Payload bytes n
    logic [63:0] id, next_id;          // Card identifier
    logic [8:0]  idx, next_idx;        // Byte position in frame
    logic [7:0]  ack, next_ack;        // Pending status byte to host
    logic        queried, next_queried; // QUERY served, stray commands return here
    logic        header_ok;            // Header check result
    logic        mem_we;               // Buffer write strobe
    logic [7:0]  mem_wdata;            // Buffer write byte
    logic [7:0]  mem_waddr;            // Buffer write slot
    logic [8:0]  rf_total;             // RF response length
    logic [7:0]  out_byte;             // Current response byte

    tunnel_check check (
        .is_iso     (rf_iso),
        .is_write   (rf_write),
        .class_byte (rf_class),
        .svc_count  (rf_svc),
        .svc_same   (rf_svc_same),
        .blk_count  (rf_blocks),
        .length     (rf_len),
        .ok         (header_ok)
    );

    // Bytes in the RF response; headers differ by framing
    always_comb begin
        if (iso) begin
            rf_total = (good && !wr) ? ({1'b0, len} + 9'd2) : 9'd2;
        end else if (!wr && good) begin
            rf_total = 9'd12 + {1'b0, len};
        end else begin
            rf_total = 9'd11;
        end
    end

    // ----------------------------------------
    // Response byte selection
    // ----------------------------------------
    always_comb begin
        out_byte = 8'h00;
        if (state == send_query) begin
            case (idx)
                9'd0:    out_byte = wr ? tunnel_pkg::stat_wr_detect : tunnel_pkg::stat_rd_detect;
                9'd1:    out_byte = addr[15:8];
                9'd2:    out_byte = addr[7:0];
                9'd3:    out_byte = len;
                default: out_byte = mem[8'(idx - 9'd4)];
            endcase
        end else if (state == send_ack) begin
            out_byte = ack;
        end else if (iso) begin
            if (idx == rf_total - 9'd2) out_byte = good ? tunnel_pkg::sw1_ok : tunnel_pkg::sw1_err;
            else if (idx == rf_total - 9'd1) out_byte = good ? tunnel_pkg::sw2_ok : tunnel_pkg::sw2_err;
            else out_byte = mem[idx[7:0]];
        end else begin
            case (idx)
                9'd0:    out_byte = wr ? tunnel_pkg::rf_write_resp_code : tunnel_pkg::rf_read_resp_code;
                9'd9:    out_byte = good ? tunnel_pkg::flag_ok : tunnel_pkg::flag_err;
                9'd10:   out_byte = good ? tunnel_pkg::flag_ok : tunnel_pkg::flag_err2;
                9'd11:   out_byte = blocks;
                default: out_byte = (idx < 9'd9) ? id[8'(9'd8 - idx) * 8 +: 8] : mem[8'(idx - 9'd12)];
            endcase
        end
    end

    // ----------------------------------------
    // Sequencer next-state logic
    // ----------------------------------------
    always_comb begin
        next_state = state;
        next_iso = iso;
        next_wr = wr;
        next_good = good;
        next_blocks = blocks;
        next_addr = addr;
        next_len = len;
        next_id = id;
        next_idx = idx;
        next_ack = ack;
        mem_we = 1'b0;
        mem_waddr = idx[7:0];
        mem_wdata = 8'h00;
        case (state)
            idle: begin
                if (rf_start) begin
                    next_iso = rf_iso;
                    next_wr = rf_write;
                    next_blocks = rf_blocks;
                    next_addr = rf_addr;
                    next_id = rf_id;
                    next_len = rf_iso ? rf_len : 8'(rf_blocks * tunnel_pkg::block_bytes);
                    next_good = header_ok;
                    next_idx = 9'd0;
                    // Rejected headers go straight to an error reply
                    if (!header_ok) next_state = send_rf;
                    else if (rf_write) next_state = gather;
                    else next_state = wait_query;
                end
            end
            gather: begin
                if (rf_in_valid) begin
                    mem_we = 1'b1;
                    mem_wdata = rf_in_data;
                    next_idx = idx + 9'd1;
                    if (idx + 9'd1 == {1'b0, len}) next_state = wait_query;
                end
            end
            wait_query, wait_answer: begin
                if (host_in_valid) begin
                    next_idx = 9'd0;
                    if (state == wait_query && host_in_data == tunnel_pkg::host_query) begin
                        next_state = send_query;
                    end else if (state == wait_answer && (host_in_data == tunnel_pkg::host_answer_ok ||
                                 host_in_data == tunnel_pkg::host_answer_err)) begin
                        next_good = host_in_data == tunnel_pkg::host_answer_ok;
                        next_ack = tunnel_pkg::stat_normal;
                        next_state = (host_in_data == tunnel_pkg::host_answer_ok && !wr && !host_in_last) ?
                                     take_data : send_ack;
                    end else begin
                        next_ack = tunnel_pkg::stat_unimpl;
                        next_state = send_ack;
                    end
                end
            end
            send_query: begin
                if (host_out_ready) begin
                    next_idx = idx + 9'd1;
                    if (host_out_last) begin
                        next_state = wait_answer;
                    end
                end
            end
            take_data: begin
                if (host_in_valid) begin
                    mem_we = 1'b1;
                    mem_wdata = host_in_data;
                    next_idx = idx + 9'd1;
                    if (host_in_last) next_state = send_ack;
                end
            end
            send_ack: begin
                if (host_out_ready) begin
                    next_idx = 9'd0;
                    // Stray commands return to waiting
                    if (ack == tunnel_pkg::stat_unimpl) next_state = queried ? wait_answer : wait_query;
                    else next_state = send_rf;
                end
            end
            send_rf: begin
                if (rf_out_ready) begin
                    next_idx = idx + 9'd1;
                    if (rf_out_last) next_state = idle;
                end
            end
            default: next_state = idle;
        endcase
    end

    // Whether a QUERY was already served for the open transaction
    always_comb begin
        next_queried = queried;
        if (state == idle) next_queried = 1'b0;
        else if (state == send_query) next_queried = 1'b1;
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state <= idle;
            iso <= 1'b0;
            wr <= 1'b0;
            good <= 1'b0;
            blocks <= 8'h00;
            addr <= 16'h0000;
            len <= 8'h00;
            id <= 64'h0;
            idx <= 9'h000;
            ack <= 8'h00;
            queried <= 1'b0;
        end else begin
            state <= next_state;
            iso <= next_iso;
            wr <= next_wr;
            good <= next_good;
            blocks <= next_blocks;
            addr <= next_addr;
            len <= next_len;
            id <= next_id;
            idx <= next_idx;
            ack <= next_ack;
            queried <= next_queried;
        end
    end

    // Payload store, no reset needed
    always_ff @(posedge clock) begin
        if (mem_we) mem[mem_waddr] <= mem_wdata;
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    always_comb begin
        host_out_valid = (state == send_query) || (state == send_ack);
        host_out_last = (state == send_ack) || (state == send_query && idx == {1'b0, len} + 9'd3 && wr) ||
                        (state == send_query && idx == 9'd3 && !wr);
        host_out_data = out_byte;
        rf_out_valid = state == send_rf;
        rf_out_last = (state == send_rf) && (idx == rf_total - 9'd1);
        rf_out_data = out_byte;
        busy = state != idle;
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    // RF reply opens only after the ANSWER status or a rejected header
    property p_rf_after_answer;
        @(posedge clock) disable iff (!resetn)
            $rose(rf_out_valid) |-> ($past(state) == send_ack || ($past(state) == idle && !good));
    endproperty
    a_rf_after_answer: assert property (p_rf_after_answer) else $error("RF reply before ANSWER");

    property p_read_code;
        @(posedge clock) disable iff (!resetn)
            (rf_out_valid && idx == 9'd0 && !iso && !wr) |-> rf_out_data == 8'h07;
    endproperty
    a_read_code: assert property (p_read_code) else $error("Wrong read response code");

    property p_err_short;
        @(posedge clock) disable iff (!resetn)
            (rf_out_valid && !iso && !good) |-> rf_total == 9'd11;
    endproperty
    a_err_short: assert property (p_err_short) else $error("Error frame not shortened");

    property p_iso_err;
        @(posedge clock) disable iff (!resetn) (rf_out_valid && iso && !good) |-> rf_total == 9'd2;
    endproperty
    a_iso_err: assert property (p_iso_err) else $error("ISO error carries data");

    property p_svc_range;
        @(posedge clock) disable iff (!resetn)
            (state == idle && rf_start && !rf_iso && rf_write && rf_svc > 8'h0b) |=> !good;
    endproperty
    a_svc_range: assert property (p_svc_range) else $error("Service count not rejected");

    property p_same;
        @(posedge clock) disable iff (!resetn)
            (state == idle && rf_start && !rf_iso && rf_write && rf_svc > 8'h01 && !rf_svc_same) |=> !good;
    endproperty
    a_same: assert property (p_same) else $error("Unequal identifiers accepted");

    property p_blk;
        @(posedge clock) disable iff (!resetn)
            (state == idle && rf_start && !rf_iso && rf_write && rf_svc > 8'h08 && rf_blocks == 8'h0c) |=> !good;
    endproperty
    a_blk: assert property (p_blk) else $error("Block count not rejected");

    property p_class;
        @(posedge clock) disable iff (!resetn)
            (state == idle && rf_start && rf_iso && rf_class != 8'h00) |=> (!good && state == send_rf);
    endproperty
    a_class: assert property (p_class) else $error("Class byte not rejected");

    property p_query_addr;
        @(posedge clock) disable iff (!resetn)
            (host_out_valid && state == send_query && idx == 9'd1) |-> host_out_data == addr[15:8];
    endproperty
    a_query_addr: assert property (p_query_addr) else $error("Address not MSB first");

    property p_ack_one;
        @(posedge clock) disable iff (!resetn) (state == send_ack) |-> host_out_last;
    endproperty
    a_ack_one: assert property (p_ack_one) else $error("ANSWER status not single byte");

    c_read: cover property (@(posedge clock) state == send_rf && !wr && good);
    c_write: cover property (@(posedge clock) state == send_rf && wr && good);
    c_err: cover property (@(posedge clock) state == send_rf && !good);
endmodule // tunnel_relay

// [host_model.sv]
// Host controller model: one QUERY/ANSWER exchange per go pulse
`timescale 1ns/1ns
module host_model (
    input  wire logic       clock,          // System clock
    input  wire logic       go,             // Start an exchange
    input  wire logic       ans_ok,         // Report normal end
    input  wire logic       is_read,        // Append read data
    input  wire logic       host_out_valid, // Device byte valid
    input  wire logic [7:0] host_out_data,  // Device byte
    input  wire logic       host_out_last,  // Last device byte
    output logic            host_out_ready, // Stalls at random
    output logic            host_in_valid,  // Command byte valid
    output logic [7:0]      host_in_data,   // Command byte
    output logic            host_in_last    // Last command byte
);
    logic [7:0] q [0:511];  // Bytes from the device
    int         qn;         // Query response length
    int         runs;       // Finished exchanges
    int         n;          // Status length
    logic [7:0] stray_ack;  // Status for a misplaced ANSWER

    // Slow and prompt host alike
    always @(posedge clock)
        host_out_ready <= 1'($urandom_range(1));

    task automatic send(input logic [7:0] b, input logic l);
        @(posedge clock);
        host_in_valid <= 1'b1;
        host_in_data  <= b;
        host_in_last  <= l;
    endtask

    // Idle bus shows the inverse, never a stale byte
    task automatic release_bus();
        @(posedge clock);
        host_in_valid <= 1'b0;
        host_in_data  <= ~host_in_data;
        host_in_last  <= 1'b0;
    endtask

    task automatic take(input int base, output int cnt);
        cnt = 0;
        do begin
            @(posedge clock);
            if (host_out_valid && host_out_ready) begin
                q[base+cnt] = host_out_data;
                cnt++;
            end
        end while (!(host_out_valid && host_out_ready && host_out_last));
    endtask

    initial begin
        host_in_valid = 1'b0;
        host_in_data  = 8'h00;
        host_in_last  = 1'b0;
        runs = 0;
        forever begin
            @(posedge clock);
            if (go) begin
                // Misplaced ANSWER before QUERY draws a status byte
                send(tunnel_pkg::host_answer_ok, 1'b1);
                release_bus();
                take(0, qn);
                stray_ack = q[0];
                send(tunnel_pkg::host_query, 1'b1);
                release_bus();
                take(0, qn);
                if (ans_ok && is_read) begin
                    send(tunnel_pkg::host_answer_ok, 1'b0);
                    for (int i = 0; i < int'(q[3]); i++)
                        send(8'(i * 37 + 5), i == int'(q[3]) - 1);
                end else
                    send(ans_ok ? tunnel_pkg::host_answer_ok : tunnel_pkg::host_answer_err, 1'b1);
                release_bus();
                take(qn, n);
                runs++;
            end
        end
    end
endmodule // host_model

// [tunnel_relay_bench.sv]
// Self-checking bench for the tunnel read/write relay
`timescale 1ns/1ns
module tunnel_relay_bench;
    logic        clock, resetn, rf_start, rf_iso, rf_write, rf_svc_same, taking;
    logic        rf_in_valid, rf_out_ready, go, ans_ok, is_read;
    logic [7:0]  rf_class, rf_svc, rf_blocks, rf_len, rf_in_data;
    logic [15:0] rf_addr;
    logic [63:0] rf_id;
    wire logic   rf_out_valid, rf_out_last, host_out_valid, host_out_last, host_out_ready;
    wire logic   host_in_valid, host_in_last, busy;
    wire logic [7:0] rf_out_data, host_out_data, host_in_data;
    int          errors, compares, tn;
    logic [7:0]  r[$], e[$];

    tunnel_relay i_dut (.clock, .resetn, .rf_start, .rf_iso, .rf_write, .rf_class, .rf_svc, .rf_svc_same,
        .rf_blocks, .rf_addr, .rf_len, .rf_id, .rf_in_valid, .rf_in_data, .rf_out_valid, .rf_out_data,
        .rf_out_last, .rf_out_ready, .host_in_valid, .host_in_data, .host_in_last, .host_out_valid,
        .host_out_data, .host_out_last, .host_out_ready, .busy);
    host_model i_host (.clock, .go, .ans_ok, .is_read, .host_out_valid, .host_out_data, .host_out_last,
        .host_out_ready, .host_in_valid, .host_in_data, .host_in_last);

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // Reader is never ready outside a reply collection, stalls at random within one
    always @(posedge clock)
        rf_out_ready <= taking && 1'($urandom_range(1));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rf_take();
        r.delete();
        taking = 1'b1;
        do begin
            @(posedge clock);
            if (rf_out_valid && rf_out_ready)
                r.push_back(rf_out_data);
        end while (!(rf_out_valid && rf_out_ready && rf_out_last));
        taking = 1'b0;
    endtask

    task automatic run(bit iso, bit wr, logic [7:0] cls, logic [7:0] svc, logic same, logic [7:0] blk,
                       logic [7:0] len, bit ok);
        bit hok, good;
        int k;
        logic [15:0] a;
        logic [63:0] id;
        a = 16'($urandom);
        id = {$urandom, $urandom};
        k = i_host.runs;
        hok = iso ? cls == 8'h00 : !wr || (svc >= 8'h01 && svc <= 8'h0b && (same || svc == 8'h01)
              && blk >= 8'h01 && blk <= (svc <= 8'h08 ? 8'h0c : 8'h0b));
        if (!iso)
            len = 8'(blk * 16);
        good = hok && ok;
        while (busy !== 1'b0)
            @(posedge clock);
        @(posedge clock);
        {rf_start, rf_iso, rf_write, rf_class, rf_svc, rf_svc_same} <= {1'b1, iso, wr, cls, svc, same};
        {rf_blocks, rf_addr, rf_len, rf_id} <= {blk, a, len, id};
        @(posedge clock);
        rf_start <= 1'b0;
        for (int i = 0; i < int'(len) && wr && hok; i++) begin
            rf_in_valid <= 1'b1;
            rf_in_data  <= 8'(i * 11 + 3);
            @(posedge clock);
        end
        rf_in_valid <= 1'b0;
        rf_in_data  <= ~rf_in_data;
        {ans_ok, is_read, go} <= {ok, !wr, hok};
        fork
            rf_take();
            begin
                @(posedge clock);
                go <= 1'b0;
                wait (i_host.runs != k || !hok);
            end
        join
        if (hok) begin
            chk(i_host.q[0], wr ? tunnel_pkg::stat_wr_detect : tunnel_pkg::stat_rd_detect);
            chk(i_host.q[1], a[15:8]);
            chk(i_host.q[2], a[7:0]);
            chk(i_host.q[3], len);
            chk(8'(i_host.qn), wr ? 8'(len + 8'h04) : 8'h04);
            for (int i = 0; i < int'(len) && wr; i++)
                chk(i_host.q[4+i], 8'(i * 11 + 3));
            chk(i_host.q[i_host.qn], 8'h00);
            chk(i_host.stray_ack, 8'h01);
        end
        e.delete();
        if (!iso) begin
            e.push_back(wr ? 8'h09 : 8'h07);
            for (int i = 7; i >= 0; i--)
                e.push_back(id[i*8+:8]);
            e.push_back(good ? 8'h00 : 8'hff);
            e.push_back(good ? 8'h00 : 8'ha1);
            if (good && !wr)
                e.push_back(blk);
        end
        for (int i = 0; i < int'(len) && good && !wr; i++)
            e.push_back(8'(i * 37 + 5));
        if (iso)
            e = {e, good ? 8'h90 : 8'h6a, good ? 8'h00 : 8'h80};
        chk(8'(r.size()), 8'(e.size()));
        foreach (e[i])
            chk(r[i], e[i]);
        tn++;
        $display("test %0d done", tn);
    endtask

    task automatic wrap_up();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        {resetn, rf_start, rf_iso, rf_write, rf_svc_same, rf_in_valid, go, ans_ok, is_read, taking} = '0;
        {rf_class, rf_svc, rf_blocks, rf_len, rf_in_data, rf_addr, rf_id} = '0;
        errors = 0;
        compares = 0;
        tn = 0;
        void'($urandom(70));
        repeat (20) @(posedge clock);
        resetn <= 1'b1;
        // read with answer ok and error
        run(0, 0, 0, 1, 1, 1, 0, 1);
        run(0, 0, 0, 1, 1, 12, 0, 0);
        run(1, 0, 0, 0, 0, 0, 251, 1);
        run(1, 0, 0, 0, 0, 0, 1, 0);
        run(0, 1, 0, 0, 1, 1, 0, 1);
        run(0, 1, 0, 12, 1, 1, 0, 1);
        run(0, 1, 0, 3, 0, 2, 0, 1);
        run(0, 1, 0, 8, 1, 12, 0, 1);
        run(0, 1, 0, 8, 1, 13, 0, 1);
        run(0, 1, 0, 9, 1, 12, 0, 1);
        run(0, 1, 0, 11, 1, 11, 0, 0);
        run(0, 1, 0, 2, 1, 0, 0, 1);
        run(1, 1, 8'h01, 0, 0, 0, 16, 1);
        run(1, 1, 0, 0, 0, 0, 248, 1);
        for (int k = 0; k < 16; k++)
            run(k[0], k[1], 8'($urandom_range(9) == 0), k[1] ? 8'($urandom_range(12)) : 8'h01,
                1'($urandom_range(4) != 0), k[1] ? 8'($urandom_range(13)) : 8'($urandom_range(12, 1)),
                8'($urandom_range(248, 1)), 1'($urandom_range(3) != 0));
        wrap_up();
    end

    initial begin
        #500_000;
        errors++;
        wrap_up();
    end
endmodule // tunnel_relay_bench
